// ==== cal_arith.sv ====
// gain multiply, offset add and saturation for one calibrated code
`timescale 1ns/1ps
module cal_arith
  import cal_engine_pkg::*;
(
  // operands
  input wire logic [15:0] raw_input_code,
  input wire logic [15:0] gain,
  input wire logic [15:0] offset,
  // result
  output logic [15:0] result
);
  logic [16:0] gain_plus_one;
  logic [32:0] product;
  logic signed [18:0] sum;

  always_comb begin
    // bit 0 of the gain is ignored
    gain_plus_one = {1'b0, gain[15:1], 1'b0} + 17'h00001;
    product = gain_plus_one * {17'h00000, raw_input_code};
    // drop the fraction by truncation
    sum = signed'({3'b000, product[31:16]}) + signed'({3'b000, offset})
      - signed'({2'b00, HALF_SCALE});
    if (sum < 0) begin
      result = 16'h0000;
    end else if (sum > signed'({3'b000, MAX_CODE})) begin
      result = MAX_CODE;
    end else begin
      result = sum[15:0];
    end
  end
endmodule

// ==== cal_engine.sv ====
// dac gain and offset calibration engine with cached results per mode
// Contract
// - calibrated code is (gain+1)/65536 times raw plus offset minus 32768
// - calibrated code delivered to the dac lies in 0 to 65535
// - raw input is a 16-bit host word, resolution sixteen bits
// - gain keeps bits 15 to 1, bit 0 ignored, resets to all ones
// - offset resets to 0x8000, midscale, no correction
// - calculation starts only on a raw input write; a mode change write loads cached results
// - gain or offset writes never recalculate; host rewrites raw input
// - each result is cached per mode or range until selected
// - result for the active set drives the dac at once, gated by load
// - force amplifier level has six register sets
// - each comparator level has six register sets with cached results
// - each clamp level has two sets: voltage, shared current ranges
// - a mode change loads the cached result of the new set
// - full 16-bit result kept even at quarter scale gain
`timescale 1ns/1ps
module cal_engine
  import cal_engine_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register writes from the serial front end
  input wire logic write_valid,
  input wire write_type write_word,
  // measurement unit mode control
  input wire logic mode_write,
  input wire set_index_type mode_set,
  input wire logic load_enable,
  // dac words and status
  output dac_words_type dac_words,
  output set_index_type active_set,
  output logic busy
);
  // flat slot of a level and set; clamps fold current ranges onto one set
  function automatic logic [SLOT_BITS-1:0] slot_of(level_type lv, set_index_type s);
    logic [SLOT_BITS-1:0] clamp_set;
    clamp_set = (s == VOLTAGE_FORCING_MODE) ? 5'h00 : 5'h01;
    case (lv)
      LEVEL_FORCE: slot_of = {2'b00, s};
      LEVEL_COMP_HIGH: slot_of = 5'h06 + {2'b00, s};
      LEVEL_COMP_LOW: slot_of = 5'h0C + {2'b00, s};
      LEVEL_CLAMP_HIGH: slot_of = 5'h12 + clamp_set;
      LEVEL_CLAMP_LOW: slot_of = 5'h14 + clamp_set;
      default: slot_of = 5'h00;
    endcase
  endfunction

  logic [15:0] raw [TOTAL_SETS];
  logic [15:0] gain [TOTAL_SETS];
  logic [15:0] offset [TOTAL_SETS];
  logic [15:0] calibrated_cached_code [TOTAL_SETS];
  logic [15:0] result;
  logic [SLOT_BITS-1:0] write_slot;
  logic [SLOT_BITS-1:0] calc_slot;
  logic calc_valid;
  logic [SLOT_BITS-1:0] latch_slot;
  logic latch_valid;
  logic [15:0] latch_result;
  logic mode_pending;
  logic set_valid;

  assign set_valid = write_word.set_index < SET_IDX_BITS'(FORCE_SETS) ? 1'b1 : 1'b0;
  assign write_slot = slot_of(write_word.level, write_word.set_index);

  // register sets
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TOTAL_SETS; i++) begin
        raw[i] <= RAW_RESET;
        // all ones, with the ignored bit 0 kept clear
        gain[i] <= {GAIN_RESET[15:1], 1'b0};
        offset[i] <= OFFSET_RESET;
      end
    end else if (write_valid && set_valid) begin
      case (write_word.field)
        FIELD_RAW: raw[write_slot] <= write_word.data;
        FIELD_GAIN: gain[write_slot] <= {write_word.data[15:1], 1'b0};
        FIELD_OFFSET: offset[write_slot] <= write_word.data;
        default: ;
      endcase
    end
  end

  // calculation is requested only by raw input writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calc_valid <= 1'b0;
      calc_slot <= 5'h00;
    end else begin
      calc_valid <= write_valid && set_valid && (write_word.field == FIELD_RAW);
      calc_slot <= write_slot;
    end
  end

  cal_arith arith (
    .raw_input_code(raw[calc_slot]),
    .gain(gain[calc_slot]),
    .offset(offset[calc_slot]),
    .result(result)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_valid <= 1'b0;
      latch_slot <= 5'h00;
      latch_result <= CODE_RESET;
    end else begin
      latch_valid <= calc_valid;
      latch_slot <= calc_slot;
      latch_result <= result;
    end
  end

  // cached results
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TOTAL_SETS; i++) begin
        calibrated_cached_code[i] <= CODE_RESET;
      end
    end else if (latch_valid) begin
      calibrated_cached_code[latch_slot] <= latch_result;
    end
  end

  // operating mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_set <= VOLTAGE_FORCING_MODE;
      mode_pending <= 1'b0;
    end else begin
      if (mode_write && mode_set < SET_IDX_BITS'(FORCE_SETS)) begin
        active_set <= mode_set;
        mode_pending <= 1'b1;
      end else if (load_enable) begin
        mode_pending <= 1'b0;
      end else if (latch_valid) begin
        // a result held back by load is reloaded from the caches later
        mode_pending <= 1'b1;
      end
    end
  end

  assign busy = calc_valid | latch_valid;

  // dac registers, one generate pass per level
  logic [15:0] dac_reg [5];
  for (genvar lv = 0; lv < 5; lv++) begin : g_level
    logic [SLOT_BITS-1:0] act_slot;
    assign act_slot = slot_of(level_type'(lv), active_set);
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        dac_reg[lv] <= CODE_RESET;
      end else if (load_enable) begin
        // a fresh result bypasses its own cache entry
        if (latch_valid && latch_slot == act_slot) begin
          dac_reg[lv] <= latch_result;
        end else if (mode_pending) begin
          dac_reg[lv] <= calibrated_cached_code[act_slot];
        end
      end
    end
  end

  assign dac_words.force_amp_level = dac_reg[0];
  assign dac_words.comp_high = dac_reg[1];
  assign dac_words.comp_low = dac_reg[2];
  assign dac_words.clamp_high = dac_reg[3];
  assign dac_words.clamp_low = dac_reg[4];

  // checks
  property p_gain_write_no_calc;
    @(posedge clock) disable iff (!rst_n)
      (write_valid && write_word.field != FIELD_RAW) |=> !calc_valid;
  endproperty
  a_gain_write_no_calc: assert property (p_gain_write_no_calc)
    else $error("gain or offset write started a calculation");

  property p_raw_write_calc;
    @(posedge clock) disable iff (!rst_n)
      (write_valid && set_valid && write_word.field == FIELD_RAW) |=> calc_valid ##1 latch_valid;
  endproperty
  a_raw_write_calc: assert property (p_raw_write_calc)
    else $error("raw write did not produce a result");

  sequence s_result_ready;
    latch_valid ##1 1'b1;
  endsequence
  property p_cache_stored;
    logic [SLOT_BITS-1:0] s;
    logic [15:0] v;
    @(posedge clock) disable iff (!rst_n)
      (latch_valid, s = latch_slot, v = latch_result) ##0 s_result_ready
        |-> calibrated_cached_code[s] == v;
  endproperty
  a_cache_stored: assert property (p_cache_stored)
    else $error("cached code not stored");

  property p_mode_load;
    @(posedge clock) disable iff (!rst_n)
      (mode_pending && load_enable && !mode_write) |=>
        dac_reg[0] == calibrated_cached_code[{2'b00, active_set}];
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode change did not load the cached code");

  property p_active_update;
    @(posedge clock) disable iff (!rst_n)
      (load_enable && latch_valid && latch_slot == {2'b00, active_set})
        |=> dac_reg[0] == $past(latch_result);
  endproperty
  a_active_update: assert property (p_active_update)
    else $error("active set result not applied");

  property p_no_load_hold;
    @(posedge clock) disable iff (!rst_n)
      !load_enable |=> $stable(dac_reg[0]);
  endproperty
  a_no_load_hold: assert property (p_no_load_hold)
    else $error("dac changed without load");

  property p_unity_cal;
    @(posedge clock) disable iff (!rst_n)
      (gain[calc_slot] == 16'hFFFE && offset[calc_slot] == OFFSET_RESET)
        |-> result == ((raw[calc_slot] == 16'h0000) ? 16'h0000 : raw[calc_slot] - 16'h0001);
  endproperty
  a_unity_cal: assert property (p_unity_cal)
    else $error("default gain and offset gave a wrong code");

  property p_saturate_low;
    @(posedge clock) disable iff (!rst_n)
      (raw[calc_slot] == 16'h0000 && offset[calc_slot] < OFFSET_RESET) |-> result == 16'h0000;
  endproperty
  a_saturate_low: assert property (p_saturate_low)
    else $error("negative result not clamped to zero");

  property p_gain_bit0;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |-> gain[0][0] == 1'b0 && gain[TOTAL_SETS-1][0] == 1'b0;
  endproperty
  a_gain_bit0: assert property (p_gain_bit0)
    else $error("gain bit 0 stored");
endmodule

// ==== cal_engine_pkg.sv ====
// shared constants and carriers for the dac calibration engine
package cal_engine_pkg;
  localparam int DAC_BITS = 16;
  localparam int SET_IDX_BITS = 3;
  localparam int FORCE_SETS = 6;
  localparam int COMP_SETS = 6;
  localparam int CLAMP_SETS = 2;
  localparam int TOTAL_SETS = FORCE_SETS + 2 * COMP_SETS + 2 * CLAMP_SETS;
  localparam int SLOT_BITS = 5;
  localparam logic [15:0] GAIN_RESET = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] RAW_RESET = 16'h0000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [16:0] HALF_SCALE = 17'h08000;
  localparam logic [15:0] MAX_CODE = 16'hFFFF;
  localparam int ENGINE_LATENCY = 2;

  // which dac level a write addresses
  typedef enum logic [2:0] {
    LEVEL_FORCE = 3'h0,
    LEVEL_COMP_HIGH = 3'h1,
    LEVEL_COMP_LOW = 3'h2,
    LEVEL_CLAMP_HIGH = 3'h3,
    LEVEL_CLAMP_LOW = 3'h4
  } level_type;

  // which register of a set a write addresses
  typedef enum logic [1:0] {
    FIELD_RAW = 2'h0,
    FIELD_GAIN = 2'h1,
    FIELD_OFFSET = 2'h2
  } field_type;

  // 0 voltage forcing, 1..4 internal current ranges, 5 external range
  typedef logic [SET_IDX_BITS-1:0] set_index_type;
  localparam set_index_type VOLTAGE_FORCING_MODE = 3'h0;

  typedef struct packed {
    level_type level;
    field_type field;
    set_index_type set_index;
    logic [15:0] data;
  } write_type;

  typedef struct packed {
    logic [15:0] force_amp_level;
    logic [15:0] comp_high;
    logic [15:0] comp_low;
    logic [15:0] clamp_high;
    logic [15:0] clamp_low;
  } dac_words_type;
endpackage

// ==== cal_host_model.sv ====
// host side model driving calibration writes and mode changes
`timescale 1ns/1ps
module cal_host_model
  import cal_engine_pkg::*;
(
  // clock
  input wire logic clock,
  // register writes and mode control
  output logic write_valid,
  output write_type write_word,
  output logic mode_write,
  output set_index_type mode_set,
  output logic load_enable
);
  initial begin
    write_valid = 1'b0;
    write_word = '0;
    mode_write = 1'b0;
    mode_set = '0;
    load_enable = 1'b1;
  end
  // one write pulse; data scrambled once the pulse ends
  task automatic put(input level_type lv, input field_type fd, input set_index_type s,
                     input logic [15:0] d);
    @(negedge clock);
    write_word = '{level: lv, field: fd, set_index: s, data: d};
    write_valid = 1'b1;
    @(negedge clock);
    write_valid = 1'b0;
    write_word.data = ~d;
  endtask
  // raw word last so the result picks up new gain and offset
  task automatic calibrate(input level_type lv, input set_index_type s,
                           input logic [15:0] g, o, r);
    put(lv, FIELD_GAIN, s, g);
    put(lv, FIELD_OFFSET, s, o);
    put(lv, FIELD_RAW, s, r);
  endtask
  task automatic change_mode(input set_index_type s);
    @(negedge clock);
    mode_set = s;
    mode_write = 1'b1;
    @(negedge clock);
    mode_write = 1'b0;
    mode_set = ~s;
  endtask
  task automatic set_load(input logic v);
    @(negedge clock);
    load_enable = v;
  endtask
endmodule

// ==== tb_dac_gain_offset_calibration_engine.sv ====
// testbench for the dac calibration engine
`timescale 1ns/1ps
module tb_dac_gain_offset_calibration_engine;
  import cal_engine_pkg::*;
  typedef struct {level_type lv; logic [15:0] g, o, r, e;} row_type;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic write_valid;
  write_type write_word;
  logic mode_write;
  set_index_type mode_set;
  logic load_enable;
  dac_words_type dac_words;
  set_index_type active_set;
  logic busy;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  row_type rows [5] = '{
    '{LEVEL_FORCE, 16'hFFFF, 16'h8000, 16'h1234, 16'h1233},
    '{LEVEL_COMP_HIGH, 16'h4000, 16'h8000, 16'hFFFF, 16'h4000},
    '{LEVEL_COMP_LOW, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF},
    '{LEVEL_CLAMP_HIGH, 16'h8000, 16'h0000, 16'h0010, 16'h0000},
    '{LEVEL_CLAMP_LOW, 16'h7FFF, 16'h8010, 16'h8000, 16'h400F}};

  always #10 clock = ~clock;

  cal_host_model u_host (
    .clock(clock), .write_valid(write_valid), .write_word(write_word),
    .mode_write(mode_write), .mode_set(mode_set), .load_enable(load_enable));

  cal_engine u_dut (
    .clock(clock), .rst_n(rst_n), .write_valid(write_valid), .write_word(write_word),
    .mode_write(mode_write), .mode_set(mode_set), .load_enable(load_enable),
    .dac_words(dac_words), .active_set(active_set), .busy(busy));

  function automatic logic [15:0] pick(input level_type lv);
    case (lv)
      LEVEL_FORCE: return dac_words.force_amp_level;
      LEVEL_COMP_HIGH: return dac_words.comp_high;
      LEVEL_COMP_LOW: return dac_words.comp_low;
      LEVEL_CLAMP_HIGH: return dac_words.clamp_high;
      default: return dac_words.clamp_low;
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle();
    repeat (4) @(negedge clock);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    check("reset_dac", 16'h0000, dac_words.force_amp_level | dac_words.comp_high);
    check("reset_set", 16'h0000, {13'h0000, active_set});
    check("reset_busy", 16'h0000, {15'h0000, busy});
    // default gain and offset applied to a first raw write
    u_host.put(LEVEL_FORCE, FIELD_RAW, 3'h0, 16'h0100);
    check("busy", 16'h0001, {15'h0000, busy});
    settle();
    check("default_cal", 16'h00FF, dac_words.force_amp_level);
    // table of calibrations on the active voltage set
    foreach (rows[i]) begin
      u_host.calibrate(rows[i].lv, 3'h0, rows[i].g, rows[i].o, rows[i].r);
      settle();
      check("row_result", rows[i].e, pick(rows[i].lv));
    end
    // gain and offset writes alone leave the result untouched
    u_host.put(LEVEL_FORCE, FIELD_GAIN, 3'h0, 16'h4000);
    u_host.put(LEVEL_FORCE, FIELD_OFFSET, 3'h0, 16'h9000);
    settle();
    check("no_recalc", 16'h1233, dac_words.force_amp_level);
    u_host.put(LEVEL_FORCE, FIELD_RAW, 3'h0, 16'h1234);
    settle();
    check("recalc", 16'h148D, dac_words.force_amp_level);
    // preload inactive sets, then switch with load held off
    u_host.calibrate(LEVEL_FORCE, 3'h3, 16'hFFFF, 16'h8000, 16'h2000);
    u_host.calibrate(LEVEL_CLAMP_HIGH, 3'h5, 16'hFFFF, 16'h8000, 16'h0400);
    settle();
    check("cached_hold", 16'h148D, dac_words.force_amp_level);
    u_host.set_load(1'b0);
    u_host.change_mode(3'h3);
    settle();
    check("active_set", 16'h0003, {13'h0000, active_set});
    check("load_gate", 16'h148D, dac_words.force_amp_level);
    u_host.set_load(1'b1);
    settle();
    check("mode_force", 16'h1FFF, dac_words.force_amp_level);
    check("mode_clamp", 16'h03FF, dac_words.clamp_high);
    check("mode_comp", 16'h0000, dac_words.comp_high);
    // out-of-range set and mode are ignored
    u_host.change_mode(3'h7);
    u_host.put(LEVEL_FORCE, FIELD_RAW, 3'h6, 16'h8000);
    settle();
    check("bad_mode", 16'h0003, {13'h0000, active_set});
    check("bad_set", 16'h1FFF, dac_words.force_amp_level);
    u_host.change_mode(3'h0);
    settle();
    check("back_force", 16'h148D, dac_words.force_amp_level);
    check("back_comp", 16'h4000, dac_words.comp_high);
    // mid-run reset restores default gain and offset
    @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    check("rerun_dac", 16'h0000, dac_words.force_amp_level | dac_words.comp_high);
    rst_n = 1'b1;
    u_host.put(LEVEL_FORCE, FIELD_RAW, 3'h0, 16'h0100);
    settle();
    check("rerun_default", 16'h00FF, dac_words.force_amp_level);
    end_of_test();
  end
endmodule
